// ==== hdl/tsd_pkg.sv ====
// Constants, carrier types and helpers of the tagged subtract and unsigned divide unit.
// Summary of operation
// - Tagged subtract with cc takes src_reg_a minus register or sign-extended immediate.
// - Tag overflow when either operand has bit 1 or 0 set, or 32-bit overflow.
// - Tagged subtract with cc sets cc32 overflow exactly to the tag overflow.
// - Other cc32 bits and all cc64 bits follow a plain subtract.
// - Register form of tagged subtracts with instruction bits 12:5 nonzero is a bad opcode.
// - Trapping tagged subtract with tag overflow faults and writes nothing.
// - Trapping tagged subtract without tag overflow writes difference and clears cc32 overflow.
// - Both divide opcodes perform 64-by-32 unsigned division giving a 32-bit quotient.
// - Dividend is upper word over src_reg_a low word; divisor is low word of operand.
// - Inexact quotients are truncated toward zero.
// - Quotient of two to the 32nd or more writes the saturated value.
// - A quotient that fits is zero-extended to 64 bits.
// - Upper word register content after a divide is arbitrary.
// - Plain divide leaves all condition codes unchanged.
// - Divide with cc sets codes from the saturated result, clearing carries and cc64 overflow.
// - Register form of divides with instruction bits 12:5 nonzero is a bad opcode.
package tsd_pkg;

  localparam logic [5:0]  TSD_OP_TSUBCC  = 6'h21;
  localparam logic [5:0]  TSD_OP_TSUBTV  = 6'h23;
  localparam logic [5:0]  TSD_OP_UDIV    = 6'h0e;
  localparam logic [5:0]  TSD_OP_UDIVCC  = 6'h1e;
  localparam int          TSD_IMM_W      = 13;
  localparam int          TSD_RSV_MSB    = 12;
  localparam int          TSD_RSV_LSB    = 5;
  localparam int          TSD_DIV_STEPS  = 32;
  localparam logic [63:0] TSD_DIV_SAT    = 64'h0000_0000_ffff_ffff;

  localparam logic [7:0]  TSD_REG_CTRL   = 8'h00;
  localparam logic [7:0]  TSD_REG_STATUS = 8'h04;
  localparam logic [7:0]  TSD_REG_COUNT  = 8'h08;
  localparam logic [2:0]  TSD_HSIZE_WORD = 3'h2;
  localparam logic        TSD_CTRL_EN_RST = 1'h1;
  localparam int          TSD_ST_BUSY    = 0;
  localparam int          TSD_ST_BAD     = 1;
  localparam int          TSD_ST_TAG     = 2;
  localparam int          TSD_ST_ZDIV    = 3;
  localparam int          TSD_ST_QOVF    = 4;
  localparam int          TSD_ST_CC      = 8;

  typedef enum logic [1:0] {
    TSD_IDLE = 2'b00,
    TSD_DIV  = 2'b01
  } tsd_phase_t;

  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } tsd_cc_t;

  typedef struct packed {
    tsd_cc_t x;
    tsd_cc_t i;
  } tsd_ccr_t;

  typedef struct packed {
    logic [5:0]           opx;
    logic                 imm_sel;
    logic [TSD_IMM_W-1:0] instr_lo;
    logic [63:0]          a;
    logic [63:0]          b;
    logic [31:0]          upper;
  } tsd_issue_t;

  typedef struct packed {
    logic        dest_we;
    logic [63:0] dest;
    logic        cc_we;
    tsd_ccr_t    ccr;
    logic        upper_we;
    logic [31:0] upper;
    logic        bad_opcode;
    logic        tag_ovf;
    logic        zero_div;
  } tsd_result_t;

  function automatic logic [63:0] tsd_sext_imm(input logic [TSD_IMM_W-1:0] imm);
    return {{(64-TSD_IMM_W){imm[TSD_IMM_W-1]}}, imm};
  endfunction

  function automatic logic tsd_bad_fmt(input logic imm_sel, input logic [TSD_IMM_W-1:0] lo);
    return !imm_sel && (|lo[TSD_RSV_MSB:TSD_RSV_LSB]);
  endfunction

endpackage

// ==== hdl/tsd_tsub.sv ====
// Subtractor producing the difference, plain subtract codes and the tag overflow flag.
`timescale 1ns/1ps
`default_nettype none
module tsd_tsub
  import tsd_pkg::*;
(
  input  wire logic [63:0] a,
  input  wire logic [63:0] b,
  output logic [63:0]      diff,
  output tsd_ccr_t         ccr,
  output logic             tag_ovf
);
  logic [64:0] full;

  always_comb begin
    full   = {1'b0, a} - {1'b0, b};
    diff   = full[63:0];
    ccr.x.n = diff[63];
    ccr.x.z = (diff == '0);
    ccr.x.v = (a[63] ^ b[63]) & (diff[63] ^ a[63]);
    ccr.x.c = full[64];
    ccr.i.n = diff[31];
    ccr.i.z = (diff[31:0] == '0);
    ccr.i.v = (a[31] ^ b[31]) & (diff[31] ^ a[31]);
    ccr.i.c = (a[31:0] < b[31:0]);
    tag_ovf = (|a[1:0]) | (|b[1:0]) | ccr.i.v;
  end
endmodule // tsd_tsub
`default_nettype wire

// ==== hdl/tsd_udiv.sv ====
// Sequential restoring divider, 64-bit dividend by 32-bit divisor.
`timescale 1ns/1ps
`default_nettype none
module tsd_udiv
  import tsd_pkg::*;
#(
  parameter int STEPS = TSD_DIV_STEPS
)
(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        start,
  input  wire logic [63:0] dividend,
  input  wire logic [31:0] divisor,
  output logic             done,
  output logic [31:0]      quot,
  output logic [31:0]      rem,
  output logic             ovf
);
  typedef struct packed {
    logic        busy;
    logic        done;
    logic        ovf;
    logic [5:0]  cnt;
    logic [31:0] rem;
    logic [31:0] quo;
    logic [31:0] dvs;
  } tsd_udiv_st_t;

  tsd_udiv_st_t st;
  tsd_udiv_st_t next_st;

  // The quotient fits in 32 bits only if the upper word is below the divisor,
  // so overflow is known before any step and costs no iterations.
  always_comb begin
    logic [32:0] trial;
    trial = {st.rem, st.quo[31]};
    next_st = st;
    next_st.done = 1'b0;
    if (start && !st.busy) begin
      next_st.busy = 1'b1;
      next_st.ovf  = (dividend[63:32] >= divisor);
      next_st.cnt  = next_st.ovf ? 6'h0 : 6'(STEPS);
      next_st.rem  = dividend[63:32];
      next_st.quo  = dividend[31:0];
      next_st.dvs  = divisor;
    end else if (st.busy) begin
      if (st.cnt == 6'h0) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end else begin
        next_st.cnt = st.cnt - 6'h1;
        // Restoring steps drop the remainder, so the quotient truncates.
        if (trial >= {1'b0, st.dvs}) begin
          next_st.rem = 32'(trial - {1'b0, st.dvs});
          next_st.quo = {st.quo[30:0], 1'b1};
        end else begin
          next_st.rem = trial[31:0];
          next_st.quo = {st.quo[30:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign done = st.done;
  assign quot = st.quo;
  assign rem  = st.rem;
  assign ovf  = st.ovf;
endmodule // tsd_udiv
`default_nettype wire

// ==== hdl/tsd_unit.sv ====
// Tagged subtract and unsigned divide execution unit with its AHB-Lite register slave.
//
// Chosen here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module tsd_unit
  import tsd_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire tsd_issue_t  issue,
  input  wire logic        issue_valid,
  output logic             issue_ready,
  output tsd_result_t      res,
  output logic             res_valid,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata
);
  typedef struct packed {
    tsd_phase_t  phase;
    logic [5:0]  op;
    logic        qovf;
    logic        res_valid;
    tsd_result_t res;
    logic        en;
    logic [3:0]  flt;
    logic [31:0] count;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] hrdata;
  } tsd_unit_st_t;

  tsd_unit_st_t st;
  tsd_unit_st_t next_st;

  logic [63:0] b_op;
  logic [63:0] sub_diff;
  tsd_ccr_t    sub_ccr;
  logic        sub_tag;
  logic        legal;
  logic        take;
  logic        is_tsub;
  logic        is_div;
  logic        div_start;
  logic        div_done;
  logic [31:0] div_quot;
  logic [31:0] div_rem;
  logic        div_ovf;
  logic        bus_sel;

  assign b_op    = issue.imm_sel ? tsd_sext_imm(issue.instr_lo) : issue.b;
  assign legal   = !tsd_bad_fmt(issue.imm_sel, issue.instr_lo);
  assign is_tsub = (issue.opx == TSD_OP_TSUBCC) || (issue.opx == TSD_OP_TSUBTV);
  assign is_div  = (issue.opx == TSD_OP_UDIV) || (issue.opx == TSD_OP_UDIVCC);
  assign issue_ready = st.en && (st.phase == TSD_IDLE);
  assign take    = issue_valid && issue_ready;
  assign bus_sel = hsel && hready && htrans[1];

  tsd_tsub u_tsub (
    .a       (issue.a),
    .b       (b_op),
    .diff    (sub_diff),
    .ccr     (sub_ccr),
    .tag_ovf (sub_tag)
  );

  tsd_udiv #(
    .STEPS (TSD_DIV_STEPS)
  ) u_udiv (
    .mclk     (mclk),
    .nrst     (nrst),
    .start    (div_start),
    .dividend ({issue.upper, issue.a[31:0]}),
    .divisor  (b_op[31:0]),
    .done     (div_done),
    .quot     (div_quot),
    .rem      (div_rem),
    .ovf      (div_ovf)
  );

  always_comb begin
    logic [63:0] q;
    logic [31:0] rd;
    q  = '0;
    rd = '0;
    next_st = st;
    next_st.res_valid = 1'b0;
    div_start = 1'b0;
    if (take) begin
      next_st.op   = issue.opx;
      next_st.res  = '0;
      next_st.qovf = 1'b0;
      case (issue.opx)
        TSD_OP_TSUBCC, TSD_OP_TSUBTV: begin
          next_st.res_valid = 1'b1;
          if (!legal) begin
            next_st.res.bad_opcode = 1'b1;
          end else if (issue.opx == TSD_OP_TSUBTV && sub_tag) begin
            next_st.res.tag_ovf = 1'b1;
          end else begin
            next_st.res.dest_we = 1'b1;
            next_st.res.dest    = sub_diff;
            next_st.res.cc_we   = 1'b1;
            next_st.res.ccr     = sub_ccr;
            // Only cc32 overflow carries the tag condition; it is clear for the trap form.
            next_st.res.ccr.i.v = (issue.opx == TSD_OP_TSUBCC) && sub_tag;
            if (issue.opx == TSD_OP_TSUBTV) begin
              next_st.res.ccr.i.v = 1'b0;
            end
          end
        end
        TSD_OP_UDIV, TSD_OP_UDIVCC: begin
          if (!legal) begin
            next_st.res.bad_opcode = 1'b1;
            next_st.res_valid      = 1'b1;
          end else if (b_op[31:0] == '0) begin
            next_st.res.zero_div = 1'b1;
            next_st.res_valid    = 1'b1;
          end else begin
            div_start     = 1'b1;
            next_st.phase = TSD_DIV;
          end
        end
        default: begin
          // Opcodes of other units are absorbed with an empty result.
          next_st.res_valid = 1'b1;
        end
      endcase
    end else if (st.phase == TSD_DIV && div_done) begin
      q = div_ovf ? TSD_DIV_SAT : {32'h0, div_quot};
      next_st.phase        = TSD_IDLE;
      next_st.qovf         = div_ovf;
      next_st.res_valid    = 1'b1;
      next_st.res.dest_we  = 1'b1;
      next_st.res.dest     = q;
      // The partial remainder is left in the upper word; callers may not use it.
      next_st.res.upper_we = 1'b1;
      next_st.res.upper    = div_rem;
      if (st.op == TSD_OP_UDIVCC) begin
        next_st.res.cc_we   = 1'b1;
        next_st.res.ccr.i.n = q[31];
        next_st.res.ccr.i.z = (q[31:0] == '0);
        next_st.res.ccr.i.v = div_ovf;
        next_st.res.ccr.i.c = 1'b0;
        next_st.res.ccr.x.n = q[63];
        next_st.res.ccr.x.z = (q == '0);
        next_st.res.ccr.x.v = 1'b0;
        next_st.res.ccr.x.c = 1'b0;
      end else begin
        next_st.res.cc_we = 1'b0;
      end
    end

    if (next_st.res_valid) begin
      next_st.flt = {next_st.qovf, next_st.res.zero_div,
                     next_st.res.tag_ovf, next_st.res.bad_opcode};
    end

    // Data phase of a bus write. A completion in the same cycle still counts.
    if (st.wr_pend) begin
      if (st.wr_addr == TSD_REG_CTRL) begin
        next_st.en = hwdata[0];
      end else if (st.wr_addr == TSD_REG_COUNT) begin
        next_st.count = '0;
      end
    end
    if (next_st.res_valid) begin
      next_st.count = next_st.count + 32'h1;
    end

    // Address phase. Reads see this cycle's write, so no stale word follows a write.
    next_st.wr_pend = bus_sel && hwrite && (hsize == TSD_HSIZE_WORD);
    next_st.wr_addr = haddr[7:0];
    if (bus_sel && !hwrite) begin
      case (haddr[7:0])
        TSD_REG_CTRL: begin
          rd[0] = next_st.en;
        end
        TSD_REG_STATUS: begin
          rd[TSD_ST_BUSY]     = (st.phase == TSD_DIV);
          rd[TSD_ST_BAD]      = next_st.flt[0];
          rd[TSD_ST_TAG]      = next_st.flt[1];
          rd[TSD_ST_ZDIV]     = next_st.flt[2];
          rd[TSD_ST_QOVF]     = next_st.flt[3];
          rd[TSD_ST_CC +: 8]  = next_st.res.ccr;
        end
        TSD_REG_COUNT: begin
          rd = next_st.count;
        end
        default: begin
          rd = '0;
        end
      endcase
      next_st.hrdata = rd;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      st    <= '0;
      st.en <= TSD_CTRL_EN_RST;
    end else begin
      st <= next_st;
    end
  end

  assign res       = st.res;
  assign res_valid = st.res_valid;
  assign hrdata    = st.hrdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  default clocking tsd_cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  sequence tsub_go_s;
    take && is_tsub && legal;
  endsequence

  sequence div_go_s;
    take && div_start;
  endsequence

  sequence div_end_s;
    res_valid && (st.op == TSD_OP_UDIV || st.op == TSD_OP_UDIVCC) && res.dest_we;
  endsequence

  sequence div_short_s;
    div_go_s ##0 (issue.upper >= b_op[31:0]);
  endsequence

  sequence div_long_s;
    div_go_s ##0 (issue.upper < b_op[31:0]);
  endsequence

  tsub_value_a: assert property (
    tsub_go_s ##0 issue.opx == TSD_OP_TSUBCC |=>
      res_valid && res.dest == $past(issue.a) - $past(b_op))
    else $error("Tagged difference wrong or late.");

  tag_bits_a: assert property (
    tsub_go_s ##0 (issue.opx == TSD_OP_TSUBCC && (|issue.a[1:0] || |b_op[1:0])) |=>
      res.ccr.i.v)
    else $error("Tag bits did not flag overflow.");

  tag_clear_a: assert property (
    tsub_go_s ##0 (issue.opx == TSD_OP_TSUBCC && !sub_tag) |=> !res.ccr.i.v)
    else $error("Overflow flag set without tag overflow.");

  xcc_plain_a: assert property (
    tsub_go_s ##0 !(issue.opx == TSD_OP_TSUBTV && sub_tag) |=>
      res.ccr.x == $past(sub_ccr.x) && res.ccr.i.c == $past(sub_ccr.i.c))
    else $error("Subtract codes differ from a plain subtract.");

  bad_fmt_a: assert property (
    take && (is_tsub || is_div) && !legal |=>
      res_valid && res.bad_opcode && !res.dest_we && !res.cc_we)
    else $error("Reserved field not refused.");

  trap_hold_a: assert property (
    tsub_go_s ##0 (issue.opx == TSD_OP_TSUBTV && sub_tag) |=>
      res.tag_ovf && !res.dest_we && !res.cc_we)
    else $error("Trapping subtract wrote state.");

  trap_pass_a: assert property (
    tsub_go_s ##0 (issue.opx == TSD_OP_TSUBTV && !sub_tag) |=>
      res.dest_we && res.cc_we && !res.ccr.i.v && !res.tag_ovf)
    else $error("Trapping subtract did not complete.");

  div_wait_a: assert property (
    div_go_s |=> !issue_ready ##[1:34] res_valid)
    else $error("Divide result outside its window.");

  sat_val_a: assert property (
    div_end_s ##0 st.qovf |-> res.dest == TSD_DIV_SAT)
    else $error("Quotient overflow not saturated.");

  zext_a: assert property (
    div_end_s ##0 !st.qovf |-> res.dest[63:32] == '0)
    else $error("Quotient not zero-extended.");

  div_nocc_a: assert property (
    res_valid && st.op == TSD_OP_UDIV |-> !res.cc_we)
    else $error("Plain divide touched condition codes.");

  divcc_a: assert property (
    div_end_s ##0 st.op == TSD_OP_UDIVCC |-> res.cc_we && res.ccr.i.v == st.qovf &&
      res.ccr.i.n == res.dest[31] && res.ccr.x.z == (res.dest == '0) &&
      !res.ccr.i.c && !res.ccr.x.v && !res.ccr.x.c)
    else $error("Divide codes wrong.");

  zero_div_a: assert property (
    take && is_div && legal && b_op[31:0] == '0 |=>
      res_valid && res.zero_div && !res.dest_we && !res.cc_we && !res.upper_we)
    else $error("Zero divisor not faulted.");

  imm_sext_a: assert property (
    tsub_go_s ##0 (issue.opx == TSD_OP_TSUBCC && issue.imm_sel) |=>
      res.dest == $past(issue.a) -
        {{(64-TSD_IMM_W){$past(issue.instr_lo[TSD_IMM_W-1])}}, $past(issue.instr_lo)})
    else $error("Immediate operand not sign-extended.");

  sign_ovf_a: assert property (
    tsub_go_s ##0 (issue.opx == TSD_OP_TSUBCC && issue.a[1:0] == 2'h0 &&
                   b_op[1:0] == 2'h0) |=>
      res.ccr.i.v == ($past(issue.a[31]) != $past(b_op[31]) &&
                      res.dest[31] != $past(issue.a[31])))
    else $error("Sign overflow did not set the narrow overflow flag.");

  xcc_ovf_a: assert property (
    tsub_go_s ##0 !(issue.opx == TSD_OP_TSUBTV && sub_tag) |=>
      res.ccr.x.v == ($past(issue.a[63]) != $past(b_op[63]) &&
                      res.dest[63] != $past(issue.a[63])))
    else $error("Wide overflow flag not from the wide subtract.");

  nz_codes_a: assert property (
    tsub_go_s ##0 !(issue.opx == TSD_OP_TSUBTV && sub_tag) |=>
      res.ccr.i.n == res.dest[31] && res.ccr.i.z == (res.dest[31:0] == '0) &&
      res.ccr.x.n == res.dest[63] && res.ccr.x.z == (res.dest == '0))
    else $error("Sign or zero codes of the difference wrong.");

  fault_quiet_a: assert property (
    res_valid && (res.bad_opcode || res.tag_ovf || res.zero_div) |->
      !res.dest_we && !res.cc_we && !res.upper_we)
    else $error("Faulting instruction wrote state.");

  sat_time_a: assert property (
    div_short_s |=> ##2 res_valid && res.dest == TSD_DIV_SAT)
    else $error("Overflowing divide not saturated on time.");

  div_time_a: assert property (
    div_long_s |=> ##34 res_valid && res.dest[63:32] == '0)
    else $error("Divide result late or not zero-extended.");

  // A quotient is right when it times the divisor stays within the dividend
  // and one more would pass it, which also proves truncation toward zero.
  div_quot_a: assert property (
    div_long_s |=> ##34
      {32'h0, res.dest[31:0]} * {32'h0, $past(b_op[31:0], 35)} <=
        {$past(issue.upper, 35), $past(issue.a[31:0], 35)} &&
      ({32'h0, res.dest[31:0]} + 64'h1) * {32'h0, $past(b_op[31:0], 35)} >
        {$past(issue.upper, 35), $past(issue.a[31:0], 35)})
    else $error("Quotient wrong.");

endmodule // tsd_unit
`default_nettype wire

// ==== sim/tsd_issuer.sv ====
// Behavioural issue side: presents one instruction at a time and collects its result.
`timescale 1ns/1ps
`default_nettype none
module tsd_issuer
  import tsd_pkg::*;
(
  input  wire logic        mclk,
  output tsd_issue_t       issue,
  output logic             issue_valid,
  input  wire logic        issue_ready,
  input  wire tsd_result_t res,
  input  wire logic        res_valid
);

  initial begin
    issue       = '0;
    issue_valid = 1'b0;
  end

  // The gap argument lets the issue side be prompt or slow.
  task automatic run(input tsd_issue_t i, input int gap, output tsd_result_t r,
                     output logic ok);
    int n;
    ok = 1'b0;
    r  = '0;
    repeat (gap + 1) @(posedge mclk);
    issue       <= i;
    issue_valid <= 1'b1;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (issue_ready !== 1'b1 && n < 200);
    @(posedge mclk);
    // Once taken, the operand bus shows the inverse so that stale values cannot pass.
    issue       <= ~i;
    issue_valid <= 1'b0;
    for (n = 0; n < 100 && !ok; n++) begin
      @(negedge mclk);
      if (res_valid === 1'b1) begin
        r  = res;
        ok = 1'b1;
      end
    end
  endtask

endmodule // tsd_issuer
`default_nettype wire

// ==== sim/tsd_unit_test.sv ====
// Self-checking bench for the tagged subtract and unsigned divide unit.
`timescale 1ns/1ps
`default_nettype none
module tsd_unit_test
  import tsd_pkg::*;
;
  logic        mclk;
  logic        nrst;
  tsd_issue_t  issue;
  logic        issue_valid;
  logic        issue_ready;
  tsd_result_t res;
  logic        res_valid;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire logic   hready;
  logic        hresp;
  logic [31:0] hrdata;
  logic [31:0] rd;
  int          n_errors;
  int          samples_checked;
  int          n_ops;

  tsd_unit uut (
    .mclk(mclk), .nrst(nrst), .issue(issue), .issue_valid(issue_valid),
    .issue_ready(issue_ready), .res(res), .res_valid(res_valid), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata)
  );

  tsd_issuer u_iss (
    .mclk(mclk), .issue(issue), .issue_valid(issue_valid), .issue_ready(issue_ready),
    .res(res), .res_valid(res_valid)
  );

  task automatic results();
    $display("checked %0d values, %0d mismatches", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [127:0] seen, input logic [127:0] expv, input string what);
    samples_checked++;
    if (seen !== expv) begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] q);
    @(posedge mclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize  <= TSD_HSIZE_WORD;
    do @(posedge mclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= wd;
    do @(posedge mclk); while (hready !== 1'b1);
    q = hrdata;
    check(128'(hresp), 128'h0, "bus response");
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string what);
    ahb(1'b0, a, 32'h0, rd);
    check(128'(rd), 128'(e), what);
  endtask

  // Reference behaviour of one instruction, worked out independently of the design.
  function automatic tsd_result_t model(input tsd_issue_t i);
    tsd_result_t r;
    logic [63:0] b;
    logic [63:0] d;
    logic [63:0] q;
    logic        tv;
    logic        sub;
    logic        div;
    r   = '0;
    b   = i.imm_sel ? {{51{i.instr_lo[12]}}, i.instr_lo} : i.b;
    sub = i.opx == TSD_OP_TSUBCC || i.opx == TSD_OP_TSUBTV;
    div = i.opx == TSD_OP_UDIV || i.opx == TSD_OP_UDIVCC;
    r.bad_opcode = (sub || div) && !i.imm_sel && (|i.instr_lo[12:5]);
    if (r.bad_opcode || !(sub || div))
      return r;
    if (sub) begin
      d  = i.a - b;
      tv = (|i.a[1:0]) || (|b[1:0]) || (i.a[31] != b[31] && d[31] != i.a[31]);
      r.ccr.i = {d[31], d[31:0] == 32'h0, tv, i.a[31:0] < b[31:0]};
      r.ccr.x = {d[63], d == 64'h0, i.a[63] != b[63] && d[63] != i.a[63], i.a < b};
      if (i.opx == TSD_OP_TSUBTV && tv) begin
        r.tag_ovf = 1'b1;
      end else begin
        r.dest_we = 1'b1;
        r.dest    = d;
        r.cc_we   = 1'b1;
      end
    end else if (b[31:0] == 32'h0) begin
      r.zero_div = 1'b1;
    end else begin
      q = {i.upper, i.a[31:0]} / {32'h0, b[31:0]};
      d = (q[63:32] != 32'h0) ? TSD_DIV_SAT : {32'h0, q[31:0]};
      r.dest_we  = 1'b1;
      r.dest     = d;
      r.upper_we = 1'b1;
      r.cc_we    = i.opx == TSD_OP_UDIVCC;
      r.ccr = {d[63], d == 64'h0, 2'b00, d[31], d[31:0] == 32'h0, q[63:32] != 32'h0, 1'b0};
    end
    return r;
  endfunction

  // Fields that carry no meaning for a given outcome are cleared before comparing.
  function automatic tsd_result_t norm(input tsd_result_t r, input logic [5:0] op);
    tsd_result_t n;
    n       = r;
    n.upper = 32'h0;
    if (!n.dest_we)
      n.dest = 64'h0;
    if (!n.cc_we)
      n.ccr = '0;
    if (op == TSD_OP_TSUBCC)
      n.tag_ovf = 1'b0;
    return n;
  endfunction

  task automatic t(input logic [5:0] op, input logic s, input logic [12:0] lo,
                   input logic [63:0] a, input logic [63:0] b, input logic [31:0] up);
    tsd_issue_t  i;
    tsd_result_t g;
    logic        ok;
    i = '{opx: op, imm_sel: s, instr_lo: lo, a: a, b: b, upper: up};
    u_iss.run(i, n_ops % 3, g, ok);
    n_ops++;
    check(128'(ok), 128'h1, "no result");
    check(128'(norm(g, op)), 128'(norm(model(i), op)), "result");
  endtask

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Expected run is a few hundred cycles; this limit is about twenty thousand.
  initial begin
    #100000;
    n_errors++;
    results();
  end

  initial begin
    nrst = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0;
    n_errors = 0;
    samples_checked = 0;
    n_ops = 0;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    rchk(TSD_REG_CTRL, 32'(TSD_CTRL_EN_RST), "control after reset");
    rchk(TSD_REG_COUNT, 32'h0, "count after reset");
    rchk(8'h10, 32'h0, "unmapped read");
    $display("test registers done");
    t(TSD_OP_TSUBCC, 1'b0, 13'h0, 64'h8, 64'h4, 32'h0);
    t(TSD_OP_TSUBCC, 1'b0, 13'h0, 64'h9, 64'h4, 32'h0);
    t(TSD_OP_TSUBCC, 1'b1, 13'h1ffc, 64'h8, 64'h5, 32'h0);
    t(TSD_OP_TSUBCC, 1'b0, 13'h0, 64'h8000_0000, 64'h4, 32'h0);
    t(TSD_OP_TSUBCC, 1'b0, 13'h0, 64'h0, 64'h4, 32'h0);
    t(TSD_OP_TSUBCC, 1'b0, 13'h0, 64'h8000_0000_0000_0000, 64'h4, 32'h0);
    t(TSD_OP_TSUBCC, 1'b0, 13'h0020, 64'h8, 64'h4, 32'h0);
    t(TSD_OP_TSUBTV, 1'b0, 13'h0, 64'h8, 64'h4, 32'h0);
    t(TSD_OP_TSUBTV, 1'b0, 13'h0, 64'h8, 64'h6, 32'h0);
    t(TSD_OP_TSUBTV, 1'b1, 13'h0002, 64'h8, 64'h0, 32'h0);
    t(TSD_OP_TSUBTV, 1'b0, 13'h0, 64'h8000_0000, 64'h4, 32'h0);
    t(TSD_OP_TSUBTV, 1'b0, 13'h1000, 64'h8, 64'h4, 32'h0);
    $display("test tagged subtract done");
    t(TSD_OP_UDIV, 1'b0, 13'h0, 64'hb, 64'h4, 32'h0);
    t(TSD_OP_UDIVCC, 1'b0, 13'h0, 64'hffff_0000_0000_000b, 64'h4, 32'h0);
    t(TSD_OP_UDIVCC, 1'b0, 13'h0, 64'hffff_ffff, 64'h4, 32'h3);
    t(TSD_OP_UDIVCC, 1'b0, 13'h0, 64'h0, 64'h4, 32'h4);
    t(TSD_OP_UDIV, 1'b0, 13'h0, 64'h0, 64'h1, 32'h5);
    t(TSD_OP_UDIVCC, 1'b0, 13'h0, 64'h0, 64'h7, 32'h0);
    t(TSD_OP_UDIVCC, 1'b1, 13'h1fff, 64'hffff_ffff, 64'h0, 32'h7fff_ffff);
    t(TSD_OP_UDIV, 1'b0, 13'h0, 64'h5, 64'h1_0000_0000, 32'h0);
    t(TSD_OP_UDIVCC, 1'b1, 13'h0, 64'h5, 64'h0, 32'h0);
    t(6'h3f, 1'b0, 13'h0, 64'h5, 64'h3, 32'h0);
    fork
      t(TSD_OP_UDIV, 1'b0, 13'h0, 64'h64, 64'h7, 32'h0);
      begin
        repeat (10) @(negedge mclk);
        check(128'(issue_ready), 128'h0, "ready during divide");
        rchk(TSD_REG_STATUS, 32'h1, "busy during divide");
      end
    join
    t(TSD_OP_UDIV, 1'b0, 13'h0100, 64'h64, 64'h7, 32'h0);
    $display("test divide done");
    ahb(1'b0, TSD_REG_STATUS, 32'h0, rd);
    check(128'(rd[4:0]), 128'h2, "status after bad format");
    ahb(1'b1, TSD_REG_STATUS, 32'hffff_ffff, rd);
    ahb(1'b0, TSD_REG_STATUS, 32'h0, rd);
    check(128'(rd[4:0]), 128'h2, "status is read only");
    rchk(TSD_REG_COUNT, 32'(n_ops), "result count");
    ahb(1'b1, TSD_REG_COUNT, 32'h0, rd);
    rchk(TSD_REG_COUNT, 32'h0, "count cleared");
    ahb(1'b1, TSD_REG_CTRL, 32'h0, rd);
    @(negedge mclk);
    check(128'(issue_ready), 128'h0, "ready while disabled");
    rchk(TSD_REG_CTRL, 32'h0, "control written");
    ahb(1'b1, TSD_REG_CTRL, 32'h1, rd);
    @(negedge mclk);
    check(128'(issue_ready), 128'h1, "ready after enable");
    t(TSD_OP_TSUBCC, 1'b0, 13'h0, 64'h4, 64'h8, 32'h0);
    $display("test registers and flow done");
    results();
  end

endmodule // tsd_unit_test
`default_nettype wire
